/* hw/timer16.sv */
// Cascaded 16-bit timer, event counter and PWM generator with APB registers
`default_nettype none

// Functional notes
// - Timer mode counts selected prescaled internal clock.
// - Timer match raises interrupt and clears counter.
// - After match, counter keeps counting unaided.
// - Period compare unbuffered; software leaves it running.
// - Timer clock choices, restricted in low speed.
// - Event mode counts falling edges, matches, clears.
// - PWM counts internal clock or external input.
// - PWM duty match inverts output flop.
// - PWM overflow inverts, clears, raises interrupt.
// - Flop resets zero, presettable, pin inverted.
// - PWM duty double-buffered, loaded on match.
// - Duty read returns active, not pending value.
// - Stop holds pin; preset only after stop.
// - Clearing run bit stops; bit 7 presets.
// - PWM adds low, high/2, high clock choices.
module timer16
    import timer16_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // APB slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]     prdata,
    output logic            pready,
    output logic            pslverr,
    // Clocking and power mode
    input  wire logic       low_clock,
    input  wire logic       low_speed_mode,
    // Pins
    input  wire logic       event_input_pin,
    output logic            pwm_out_pin,
    // Event to interrupt controller
    output logic            match_interrupt
);
    import timer16_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]  lower_ctrl_q;         // Clock select, tap select
    logic [7:0]  upper_ctrl_q;         // Initial value, run, mode
    logic [15:0] period_q;             // Period compare, both bytes
    logic [15:0] duty_buf_q;           // Duty value written by software
    logic [15:0] duty_act_q;           // Duty value in use
    logic [15:0] count_q;              // Cascaded up-counter
    logic        flop_q;               // Output toggle flop
    logic        match_q;              // Registered match pulse
    logic [31:0] prdata_q;             // Read data register
    logic        pslverr_q;            // Unmapped-address flag
    logic [10:0] pre_q;                // High clock prescaler
    logic [2:0]  low_div_q;            // Low clock /8 divider
    logic [2:0]  low_sync_q;           // Low clock synchroniser
    logic        low_lvl_q;            // Filtered low clock level
    logic [2:0]  ev_sync_q;            // Event pin synchroniser
    logic        ev_lvl_q;             // Filtered event level
    run_state_t  state_q;              // Counter state
    logic        low_rise;             // One cycle per low clock rising edge
    logic        low_div_tick;         // Low clock / 8
    logic        ev_fall;              // Filtered event falling edge
    logic        tick;                 // Selected count tick
    logic        running;              // Counter enabled
    logic [2:0]  mode;                 // Decoded mode field
    logic [2:0]  clk_sel;              // Decoded clock select
    logic [15:0] count_inc;            // Counter plus one
    logic        setup_ph;             // APB setup cycle
    logic        wr_acc;               // APB write completing
    logic        addr_ok;              // Address is mapped

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Prescaler tap strobe: one cycle in 2^n
    function automatic logic div_tick(input logic [10:0] pre, input int n);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < TAP_11; i++)
        begin
            if (i < n)
            begin
                hit = hit & pre[i];
            end
        end
        return hit;
    endfunction

    // Mapped-address decode, used by write and error paths
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OFS_LOWER_CTRL)  || (a == OFS_UPPER_CTRL) ||
               (a == OFS_PERIOD_LOW)  || (a == OFS_PERIOD_HIGH) ||
               (a == OFS_DUTY_LOW)    || (a == OFS_DUTY_HIGH) ||
               (a == OFS_COUNT);
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero wait state slave
    assign pready    = 1'b1;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q & psel & penable;
    assign setup_ph  = psel & ~penable;
    assign addr_ok   = is_mapped(paddr);
    assign wr_acc    = psel & penable & pwrite & addr_ok;

    assign mode      = upper_ctrl_q[MODE_LSB +: 3];
    assign clk_sel   = lower_ctrl_q[CLKSEL_LSB +: 3];
    assign running   = (state_q == ST_RUN);
    assign count_inc = count_q + 16'h0001;

    // Inverted flop level drives the pin at all times
    assign pwm_out_pin     = ~flop_q;
    assign match_interrupt = match_q;

    // ------------------------------------------------------------------
    // Read data and error, captured in the setup cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            pslverr_q <= ~addr_ok;
            prdata_q  <= 32'h0000_0000;
            case (paddr)
                OFS_LOWER_CTRL:  prdata_q[7:0]  <= lower_ctrl_q;
                OFS_UPPER_CTRL:  prdata_q[7:0]  <= upper_ctrl_q;
                OFS_PERIOD_LOW:  prdata_q[7:0]  <= period_q[7:0];
                OFS_PERIOD_HIGH: prdata_q[7:0]  <= period_q[15:8];
                // Active duty is read back, not the pending one
                OFS_DUTY_LOW:    prdata_q[7:0]  <= duty_act_q[7:0];
                OFS_DUTY_HIGH:   prdata_q[7:0]  <= duty_act_q[15:8];
                OFS_COUNT:       prdata_q[15:0] <= count_q;
                default:         prdata_q       <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lower_ctrl_q <= CTRL_RESET;
            upper_ctrl_q <= CTRL_RESET;
        end
        else if (wr_acc)
        begin
            if (paddr == OFS_LOWER_CTRL)
            begin
                lower_ctrl_q <= pwdata[7:0];
            end
            if (paddr == OFS_UPPER_CTRL)
            begin
                upper_ctrl_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Period compare, unbuffered, effective at once
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            period_q <= PERIOD_RESET;
        end
        else if (wr_acc)
        begin
            // Each byte lands directly in the comparator
            if (paddr == OFS_PERIOD_LOW)
            begin
                period_q[7:0] <= pwdata[7:0];
            end
            if (paddr == OFS_PERIOD_HIGH)
            begin
                period_q[15:8] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Duty buffer written by software
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            duty_buf_q <= DUTY_RESET;
        end
        else if (wr_acc)
        begin
            if (paddr == OFS_DUTY_LOW)
            begin
                duty_buf_q[7:0] <= pwdata[7:0];
            end
            if (paddr == OFS_DUTY_HIGH)
            begin
                duty_buf_q[15:8] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and low clock handling
    // ------------------------------------------------------------------
    // Free running high clock divider
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pre_q <= 11'h000;
        end
        else
        begin
            pre_q <= pre_q + 11'h001;
        end
    end

    // Low clock: three stages, level follows when last two agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            low_sync_q <= 3'h0;
            low_lvl_q  <= 1'b0;
        end
        else
        begin
            low_sync_q <= {low_sync_q[1:0], low_clock};
            if (low_sync_q[1] == low_sync_q[2])
            begin
                low_lvl_q <= low_sync_q[2];
            end
        end
    end

    assign low_rise = (low_sync_q[1] == low_sync_q[2]) & low_sync_q[2] & ~low_lvl_q;

    // Low clock divided by 8
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            low_div_q <= 3'h0;
        end
        else if (low_rise)
        begin
            low_div_q <= low_div_q + 3'h1;
        end
    end

    assign low_div_tick = low_rise & (low_div_q == 3'h7);

    // ------------------------------------------------------------------
    // Event input: filtered falling edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ev_sync_q <= 3'h7;
            ev_lvl_q  <= 1'b1;
        end
        else
        begin
            ev_sync_q <= {ev_sync_q[1:0], event_input_pin};
            if (ev_sync_q[1] == ev_sync_q[2])
            begin
                ev_lvl_q <= ev_sync_q[2];
            end
        end
    end

    assign ev_fall = (ev_sync_q[1] == ev_sync_q[2]) & ~ev_sync_q[2] & ev_lvl_q;

    // ------------------------------------------------------------------
    // Count tick selection
    // ------------------------------------------------------------------
    always_comb
    begin
        tick = 1'b0;
        if (mode == MODE_EVENT)
        begin
            tick = ev_fall;
        end
        else if (low_speed_mode)
        begin
            // Only low clock and external pin sources survive in low speed modes
            case (clk_sel)
                SEL_DIV11: tick = low_div_tick;
                SEL_LOW:   tick = (mode == MODE_PWM) & low_rise;
                SEL_EXT:   tick = (mode == MODE_PWM) & ev_fall;
                default:   tick = 1'b0;
            endcase
        end
        else
        begin
            case (clk_sel)
                SEL_DIV11: tick = lower_ctrl_q[BIT_TAP_SELECT] ? low_div_tick
                                                               : div_tick(pre_q, TAP_11);
                SEL_DIV7:  tick = div_tick(pre_q, TAP_7);
                SEL_DIV5:  tick = div_tick(pre_q, TAP_5);
                SEL_DIV3:  tick = div_tick(pre_q, TAP_3);
                SEL_LOW:   tick = (mode == MODE_PWM) & low_rise;
                SEL_DIV1:  tick = (mode == MODE_PWM) & div_tick(pre_q, TAP_1);
                SEL_FULL:  tick = (mode == MODE_PWM);
                SEL_EXT:   tick = (mode == MODE_PWM) & ev_fall;
                default:   tick = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Run state follows the run bit
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE: if (upper_ctrl_q[BIT_RUN])  state_q <= ST_RUN;
                ST_RUN:  if (!upper_ctrl_q[BIT_RUN]) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Cascaded counter and match pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_q <= 16'h0000;
            match_q <= 1'b0;
        end
        else
        begin
            match_q <= 1'b0;
            if (!running)
            begin
                // Stopped counter rests at zero
                count_q <= 16'h0000;
            end
            else if (tick)
            begin
                if (mode == MODE_PWM)
                begin
                    // Overflow clears and signals
                    if (count_q == COUNT_MAX)
                    begin
                        count_q <= 16'h0000;
                        match_q <= 1'b1;
                    end
                    else
                    begin
                        count_q <= count_inc;
                    end
                end
                else if ((mode == MODE_TIMER) || (mode == MODE_EVENT))
                begin
                    // Full 16-bit compare, clear and carry on
                    if (count_inc == period_q)
                    begin
                        count_q <= 16'h0000;
                        match_q <= 1'b1;
                    end
                    else
                    begin
                        count_q <= count_inc;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Active duty register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            duty_act_q <= DUTY_RESET;
        end
        else if (!running)
        begin
            // Stopped: buffer passes straight through
            duty_act_q <= duty_buf_q;
        end
        else if ((mode == MODE_PWM) && tick && (count_q == COUNT_MAX))
        begin
            // Running: loaded with the overflow match
            duty_act_q <= duty_buf_q;
        end
    end

    // ------------------------------------------------------------------
    // Output toggle flop
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            flop_q <= 1'b0;
        end
        else if (wr_acc && (paddr == OFS_UPPER_CTRL) && !upper_ctrl_q[BIT_RUN] && !running)
        begin
            // Preset only when already stopped; a stopping write holds level
            flop_q <= pwdata[BIT_INIT_VALUE];
        end
        else if (running && tick && (mode == MODE_PWM))
        begin
            if (count_q == COUNT_MAX)
            begin
                flop_q <= ~flop_q;
            end
            else if (count_inc == duty_act_q)
            begin
                flop_q <= ~flop_q;
            end
        end
    end

endmodule

`default_nettype wire

/* hw/timer16_pkg.sv */
// Register map, field layout and constants for the cascaded 16-bit timer
`default_nettype none

package timer16_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets (one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_LOWER_CTRL  = 8'h00; // lower_timer_control
    localparam logic [7:0] OFS_UPPER_CTRL  = 8'h04; // upper_timer_control
    localparam logic [7:0] OFS_PERIOD_LOW  = 8'h08; // period_compare_low
    localparam logic [7:0] OFS_PERIOD_HIGH = 8'h0C; // period_compare_high
    localparam logic [7:0] OFS_DUTY_LOW    = 8'h10; // duty_compare_low
    localparam logic [7:0] OFS_DUTY_HIGH   = 8'h14; // duty_compare_high
    localparam logic [7:0] OFS_COUNT       = 8'h18; // live counter, read only

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_INIT_VALUE = 7;   // Output flop initial value
    localparam int BIT_RUN        = 3;   // Counter run bit
    localparam int MODE_LSB       = 0;   // Mode field, upper control
    localparam int CLKSEL_LSB     = 4;   // Clock select, lower control
    localparam int BIT_TAP_SELECT = 0;   // Divider tap select, lower control

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] DUTY_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

    // ------------------------------------------------------------------
    // Modes and clock selections
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_TIMER = 3'h0;  // Interval timer
    localparam logic [2:0] MODE_EVENT = 3'h1;  // Event counter
    localparam logic [2:0] MODE_PWM   = 3'h2;  // Pulse width modulation

    localparam logic [2:0] SEL_DIV11  = 3'h0;  // high/2^11 or low/2^3
    localparam logic [2:0] SEL_DIV7   = 3'h1;  // high/2^7
    localparam logic [2:0] SEL_DIV5   = 3'h2;  // high/2^5
    localparam logic [2:0] SEL_DIV3   = 3'h3;  // high/2^3
    localparam logic [2:0] SEL_LOW    = 3'h4;  // low clock (PWM only)
    localparam logic [2:0] SEL_DIV1   = 3'h5;  // high/2 (PWM only)
    localparam logic [2:0] SEL_FULL   = 3'h6;  // high clock (PWM only)
    localparam logic [2:0] SEL_EXT    = 3'h7;  // External pin (PWM only)

    // Prescaler tap exponents
    localparam int TAP_11 = 11;
    localparam int TAP_7  = 7;
    localparam int TAP_5  = 5;
    localparam int TAP_3  = 3;
    localparam int TAP_1  = 1;

    // Counter state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } run_state_t;

endpackage

`default_nettype wire

/* sim/timer16_checker.sv */
// Port-level assertions for the cascaded 16-bit timer
`default_nettype none

module timer16_checker
    import timer16_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // APB slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pin and event
    input wire logic        pwm_out_pin,
    input wire logic        match_interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic wr_up;    // Write to upper control in access phase
    logic run_q;    // Run bit as last written by software
    assign wr_up = psel && penable && pwrite && (paddr == OFS_UPPER_CTRL);

    // ----------------------------------------------------------------
    // Run bit shadow, so stopped stretches can be recognised
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            run_q <= 1'b0;
        else if (wr_up)
            run_q <= pwdata[BIT_RUN];
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_ready_always: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    a_err_unmapped: assert property (psel && penable && paddr > OFS_COUNT |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (psel && penable && paddr[1:0] == 2'b00
        && paddr <= OFS_COUNT |-> !pslverr)
        else $error("error on mapped address");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000
        && (paddr == OFS_COUNT || prdata[15:8] == 8'h00))
        else $error("upper read bits not zero");
    a_irq_single: assert property (match_interrupt |=> !match_interrupt)
        else $error("match event longer than one cycle");
    a_reset_levels: assert property ($fell(rst) |-> pwm_out_pin && !match_interrupt)
        else $error("wrong pin or event level after reset");
    a_stop_quiet: assert property (!run_q && !$past(run_q) && !$past(run_q, 2)
        |-> !match_interrupt)
        else $error("match event while stopped");
    a_stop_holds: assert property (!run_q && !$past(run_q) && !$past(run_q, 2)
        && !$past(wr_up) && !$past(rst) |-> $stable(pwm_out_pin))
        else $error("pin moved while stopped");

    // Main scenarios reached
    c_match: cover property (match_interrupt);
    c_error: cover property (psel && penable && pslverr);
    c_pin_fall: cover property ($fell(pwm_out_pin));
endmodule

bind timer16 timer16_checker u_timer16_checker (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pwm_out_pin, .match_interrupt
);

`default_nettype wire

/* sim/timer16_tb.sv */
// Self-checking bench for the cascaded 16-bit timer
`default_nettype none

module timer16_tb;
    import timer16_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys, rst, psel, penable, pwrite, low_clock, low_speed_mode;
    logic        event_input_pin, pready, pslverr, pwm_out_pin, match_interrupt, err, pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          fail_count, compares, cycles, irq_cnt, lc_cnt, n, base;
    // Timer sources: select, tap, low speed, period, interval (0 = none)
    int          tbl [7][5] = '{'{3, 0, 0, 258, 2064}, '{2, 0, 0, 2, 64},
        '{1, 0, 0, 2, 256}, '{0, 0, 0, 2, 4096}, '{0, 1, 1, 2, 160},
        '{3, 0, 1, 2, 0}, '{6, 0, 0, 2, 0}};

    timer16 u_timer16 (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .low_clock, .low_speed_mode, .event_input_pin,
        .pwm_out_pin, .match_interrupt);

    // Clock, 20 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Low clock of ten cycles, event and cycle counts, timeout
    always @(posedge clk_sys)
    begin
        lc_cnt <= (lc_cnt == 4) ? 0 : lc_cnt + 1;
        if (lc_cnt == 4) low_clock <= ~low_clock;
        irq_cnt <= irq_cnt + int'(match_interrupt === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Cycles until the next match event, or the limit
    task wait_irq(input int lim);
        n = 0;
        do begin @(posedge clk_sys); #1; n++; end
        while (n < lim && match_interrupt !== 1'b1);
    endtask

    task wait_pin(input logic v, input int lim);
        n = 0;
        while (pwm_out_pin !== v && n < lim) begin @(posedge clk_sys); #1; n++; end
    endtask

    // Falling edges on the event pin, four cycles low and five high
    task ev(input int k);
        repeat (k) begin
            @(posedge clk_sys) event_input_pin <= 1'b0;
            repeat (4) @(posedge clk_sys);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
    endtask

    task print_verdict;
        $display("Mismatches %0d, comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; low_clock = 1'b0; low_speed_mode = 1'b0; event_input_pin = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rchk(OFS_PERIOD_LOW, 32'h000000FF);
        rchk(OFS_PERIOD_HIGH, 32'h000000FF);
        rchk(OFS_DUTY_HIGH, 32'h0);
        chk(32'(pwm_out_pin), 32'h1);
        wr(OFS_COUNT, 32'h55);
        rchk(OFS_COUNT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        // Timer sources, periods and low speed limits
        for (int i = 0; i < 7; i++) begin
            wr(OFS_UPPER_CTRL, 32'h0);
            low_speed_mode <= tbl[i][2][0];
            wr(OFS_PERIOD_HIGH, tbl[i][3] >> 8);
            wr(OFS_PERIOD_LOW, tbl[i][3] & 255);
            wr(OFS_LOWER_CTRL, 32'((tbl[i][0] << CLKSEL_LSB) | tbl[i][1]));
            wr(OFS_UPPER_CTRL, 32'h08);
            wait_irq(tbl[i][4] == 0 ? 400 : 9000);
            if (tbl[i][4] == 0) chk(n, 400);
            else begin wait_irq(9000); chk(n, tbl[i][4]); end
        end
        // Event counting on falling edges
        wr(OFS_UPPER_CTRL, 32'h0);
        wr(OFS_PERIOD_LOW, 32'h03);
        wr(OFS_PERIOD_HIGH, 32'h0);
        wr(OFS_UPPER_CTRL, 32'h09);
        base = irq_cnt;
        ev(2); chk(irq_cnt - base, 0);
        ev(1); chk(irq_cnt - base, 1);
        ev(3); chk(irq_cnt - base, 2);
        // PWM: duty buffering, toggles, stop and preset
        wr(OFS_UPPER_CTRL, 32'h02);
        wr(OFS_DUTY_LOW, 32'h10);
        wr(OFS_DUTY_HIGH, 32'h0);
        rchk(OFS_DUTY_LOW, 32'h10);
        wr(OFS_LOWER_CTRL, 32'(SEL_FULL) << CLKSEL_LSB);
        wr(OFS_UPPER_CTRL, 32'h0A);
        wait_pin(1'b0, 100); chk(32'(pwm_out_pin), 32'h0);
        base = cycles;
        wr(OFS_DUTY_LOW, 32'h20);
        wr(OFS_DUTY_HIGH, 32'h0);
        rchk(OFS_DUTY_LOW, 32'h10);
        wait_pin(1'b1, 70000); chk(cycles - base, 65520);
        chk(32'(match_interrupt), 32'h1);
        rchk(OFS_DUTY_LOW, 32'h20);
        wait_pin(1'b0, 100); chk(32'(pwm_out_pin), 32'h0);
        wr(OFS_UPPER_CTRL, 32'h02);
        #1 pin = pwm_out_pin;
        repeat (50) @(posedge clk_sys);
        #1 chk(32'(pwm_out_pin), 32'(pin));
        wr(OFS_UPPER_CTRL, 32'h02);
        #1 chk(32'(pwm_out_pin), 32'h1);
        wr(OFS_UPPER_CTRL, 32'h82);
        #1 chk(32'(pwm_out_pin), 32'h0);
        // PWM on event pin falls; the starting write loads the flop
        wr(OFS_DUTY_LOW, 32'h02);
        wr(OFS_DUTY_HIGH, 32'h0);
        wr(OFS_LOWER_CTRL, 32'(SEL_EXT) << CLKSEL_LSB);
        wr(OFS_UPPER_CTRL, 32'h0A);
        ev(1); chk(32'(pwm_out_pin), 32'h1);
        ev(1); chk(32'(pwm_out_pin), 32'h0);
        print_verdict();
    end
endmodule

`default_nettype wire
